// *** verilog/key_wake_pkg.sv ***
// Constants for the key wake-up port pair
package key_wake_pkg;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_G_OUT    = 8'h24;
	localparam logic [7:0] IDX_H_OUT    = 8'h25;
	localparam logic [7:0] IDX_G_PINS   = 8'h26;
	localparam logic [7:0] IDX_H_PINS   = 8'h27;
	localparam logic [7:0] IDX_G_DIR    = 8'h28;
	localparam logic [7:0] IDX_H_DIR    = 8'h29;
	localparam logic [7:0] IDX_G_ENA    = 8'h2b;
	localparam logic [7:0] IDX_H_ENA    = 8'h2c;
	localparam logic [7:0] IDX_G_FLAGS  = 8'h2e;
	localparam logic [7:0] IDX_H_FLAGS  = 8'h2f;
	localparam int         ADDR_W       = 12;
	// ----------------------------------------
	// Fields and reset values
	// ----------------------------------------
	localparam int         BIT_SDA      = 6;
	localparam int         BIT_SCL      = 7;
	localparam int         BIT_I2C_EN   = 7;
	localparam logic [7:0] G_FLAG_MASK  = 8'h7f;
	localparam logic [7:0] G_ENA_MASK   = 8'h7f;
	localparam logic [7:0] RST_BYTE     = 8'h00;
	// ----------------------------------------
	// Stop filter timing
	// ----------------------------------------
	localparam int         CLK_HZ       = 20_000_000;
	localparam int         FILT_TICK_NS = 1000;
	localparam int         FILT_DIV     = (FILT_TICK_NS * (CLK_HZ / 1_000_000)) / 1000;
	localparam logic [1:0] VOTE_MIN     = 2'd2;
	typedef enum logic [1:0] {
		F_IDLE  = 2'b00,
		F_ONE   = 2'b01,
		F_TWO   = 2'b11,
		F_THREE = 2'b10
	} filt_state_t;
endpackage : key_wake_pkg

// *** verilog/key_wake_port_pair.sv ***
// Two 8-bit ports with falling-edge key wake-up and an APB register slave
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
module key_wake_port_pair
	import key_wake_pkg::*;
#(
	parameter int FILT_CYCLES = FILT_DIV
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    reset_n,
	// APB slave
	input  wire logic [key_wake_pkg::ADDR_W-1:0] paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [31:0]             pwdata,
	output logic      [31:0]             prdata,
	output logic                         pready,
	output logic                         pslverr,
	// Port G pins
	input  wire logic [7:0]              port_g_in,
	output logic      [7:0]              port_g_out,
	output logic      [7:0]              port_g_oe,
	output logic      [7:0]              port_g_pull_up,
	output logic      [7:0]              port_g_pull_down,
	input  wire logic                    port_g_pull_select_pin,
	// Port H pins
	input  wire logic [7:0]              port_h_in,
	output logic      [7:0]              port_h_out,
	output logic      [7:0]              port_h_oe,
	output logic      [7:0]              port_h_pull_up,
	output logic      [7:0]              port_h_pull_down,
	input  wire logic                    port_h_pull_select_pin,
	// Low-power state and wake-up
	input  wire logic                    stop_mode,
	output logic                         wake_request,
	output logic                         stop_wake
);
	import key_wake_pkg::*;

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	logic [7:0] g_out, h_out, g_dir, h_dir, g_ena, h_ena, g_flags, h_flags;
	logic [7:0] next_g_out, next_h_out, next_g_dir, next_h_dir;
	logic [7:0] next_g_ena, next_h_ena, next_g_flags, next_h_flags;
	logic [15:0] sync_a, sync_b, prev;
	logic [15:0] filt_pend, next_filt_pend;
	filt_state_t fstate, next_fstate;
	logic [1:0]  lows, next_lows;
	logic [15:0] tick_cnt, next_tick_cnt;
	logic        tick;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr, next_wake, next_stop_wake;
	logic [7:0]  next_g_oe, next_h_oe, next_g_pout;
	logic [15:0] fall, set_run, set_stop, ena16;
	logic        start_seen, i2c_en, wr, rd, hit;
	logic [7:0]  idx, rdv, g_clr, h_clr;

	assign i2c_en = g_ena[BIT_I2C_EN];
	assign ena16  = {h_ena, g_ena & G_ENA_MASK};
	assign idx    = paddr[9:2];
	assign wr     = psel && penable && !pready && pwrite;
	assign rd     = psel && penable && !pready && !pwrite;

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	// Pin levels are watched, not the output latch, so outputs wake too
	always_comb begin
		fall       = prev & ~sync_b;
		start_seen = fall[BIT_SDA] && sync_b[BIT_SCL];
		set_run    = fall & {8'hff, G_FLAG_MASK};
		if (i2c_en)
			set_run[BIT_SDA] = start_seen;
		if (stop_mode)
			set_run = '0;
	end

	// ----------------------------------------
	// Stop filter
	// ----------------------------------------
	// Shared by all pins: a second pulse inside one vote may merge with the first
	always_comb begin
		next_tick_cnt = tick_cnt + 16'd1;
		tick          = (tick_cnt == 16'(FILT_CYCLES - 1));
		if (tick || fstate == F_IDLE)
			next_tick_cnt = '0;
		next_fstate    = fstate;
		next_lows      = lows;
		next_filt_pend = filt_pend;
		set_stop       = '0;
		case (fstate)
			F_IDLE: begin
				next_lows = '0;
				if (stop_mode && |(fall & ena16)) begin
					next_filt_pend = fall & ena16;
					next_fstate    = F_ONE;
				end
			end
			F_ONE: if (tick) begin
				next_lows   = lows + 2'(|(~sync_b & ena16));
				next_fstate = F_TWO;
			end
			F_TWO: if (tick) begin
				next_lows   = lows + 2'(|(~sync_b & ena16));
				next_fstate = F_THREE;
			end
			F_THREE: if (tick) begin
				if (lows + 2'(|(~sync_b & ena16)) >= VOTE_MIN)
					set_stop = filt_pend;
				next_fstate    = F_IDLE;
				next_filt_pend = '0;
			end
			default: next_fstate = F_IDLE;
		endcase
		if (!stop_mode) begin
			next_fstate    = F_IDLE;
			next_filt_pend = '0;
		end
	end

	// ----------------------------------------
	// Register file and APB
	// ----------------------------------------
	always_comb begin
		hit = (paddr[1:0] == 2'b00) && (paddr[ADDR_W-1:10] == '0);
		case (idx)
			IDX_G_OUT:   rdv = g_out;
			IDX_H_OUT:   rdv = h_out;
			IDX_G_PINS:  rdv = sync_b[7:0];
			IDX_H_PINS:  rdv = sync_b[15:8];
			IDX_G_DIR:   rdv = g_dir;
			IDX_H_DIR:   rdv = h_dir;
			IDX_G_ENA:   rdv = g_ena;
			IDX_H_ENA:   rdv = h_ena;
			IDX_G_FLAGS: rdv = g_flags & G_FLAG_MASK;
			IDX_H_FLAGS: rdv = h_flags;
			default: begin
				rdv = RST_BYTE;
				hit = 1'b0;
			end
		endcase
		next_pready  = psel && penable && !pready;
		next_pslverr = next_pready && !hit;
		next_prdata  = (rd && hit) ? {24'h0, rdv} : '0;
		next_g_out = g_out;
		next_h_out = h_out;
		next_g_dir = g_dir;
		next_h_dir = h_dir;
		next_g_ena = g_ena;
		next_h_ena = h_ena;
		g_clr = '0;
		h_clr = '0;
		if (wr && hit) begin
			case (idx)
				IDX_G_OUT:   next_g_out = pwdata[7:0];
				IDX_H_OUT:   next_h_out = pwdata[7:0];
				IDX_G_DIR:   next_g_dir = pwdata[7:0];
				IDX_H_DIR:   next_h_dir = pwdata[7:0];
				IDX_G_ENA:   next_g_ena = pwdata[7:0];
				IDX_H_ENA:   next_h_ena = pwdata[7:0];
				IDX_G_FLAGS: g_clr = pwdata[7:0];
				IDX_H_FLAGS: h_clr = pwdata[7:0];
				default: ;
			endcase
		end
		// A new edge in the clearing cycle survives
		next_g_flags = ((g_flags & ~g_clr) | set_run[7:0] | set_stop[7:0])
			& G_FLAG_MASK;
		next_h_flags = (h_flags & ~h_clr) | set_run[15:8] | set_stop[15:8];
	end

	// ----------------------------------------
	// Pin drivers and wake outputs
	// ----------------------------------------
	always_comb begin
		next_g_oe   = next_g_dir;
		next_h_oe   = next_h_dir;
		next_g_pout = next_g_out;
		if (next_g_ena[BIT_I2C_EN]) begin
			// Only ever pulls low, so other drivers may share the line
			next_g_oe[BIT_SDA]   = next_g_dir[BIT_SDA] && !next_g_out[BIT_SDA];
			next_g_oe[BIT_SCL]   = next_g_dir[BIT_SCL] && !next_g_out[BIT_SCL];
			next_g_pout[BIT_SDA] = 1'b0;
			next_g_pout[BIT_SCL] = 1'b0;
		end
		next_wake = |({next_h_flags, next_g_flags} & {next_h_ena, next_g_ena & G_ENA_MASK});
		// Level path: holds the request while the clock may be stopped
		next_stop_wake = stop_mode && |(~port_h_in & h_ena | ~port_g_in & ena16[7:0]);
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			g_out <= RST_BYTE;
			h_out <= RST_BYTE;
			g_dir <= RST_BYTE;
			h_dir <= RST_BYTE;
			g_ena <= RST_BYTE;
			h_ena <= RST_BYTE;
			g_flags <= RST_BYTE;
			h_flags <= RST_BYTE;
			// Chain keeps sampling so a pin held low at release is no edge
			sync_a <= {port_h_in, port_g_in};
			sync_b <= sync_a;
			prev <= sync_b;
			fstate <= F_IDLE;
			lows <= '0;
			filt_pend <= '0;
			tick_cnt <= '0;
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			port_g_out <= RST_BYTE;
			port_h_out <= RST_BYTE;
			port_g_oe <= RST_BYTE;
			port_h_oe <= RST_BYTE;
			port_g_pull_up <= RST_BYTE;
			port_g_pull_down <= RST_BYTE;
			port_h_pull_up <= RST_BYTE;
			port_h_pull_down <= RST_BYTE;
			wake_request <= 1'b0;
			stop_wake <= 1'b0;
		end else begin
			g_out <= next_g_out;
			h_out <= next_h_out;
			g_dir <= next_g_dir;
			h_dir <= next_h_dir;
			g_ena <= next_g_ena;
			h_ena <= next_h_ena;
			g_flags <= next_g_flags;
			h_flags <= next_h_flags;
			sync_a <= {port_h_in, port_g_in};
			sync_b <= sync_a;
			prev <= sync_b;
			fstate <= next_fstate;
			lows <= next_lows;
			filt_pend <= next_filt_pend;
			tick_cnt <= next_tick_cnt;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
			port_g_out <= next_g_pout;
			port_h_out <= next_h_out;
			port_g_oe <= next_g_oe;
			port_h_oe <= next_h_oe;
			port_g_pull_up <= {8{port_g_pull_select_pin}};
			port_g_pull_down <= {8{!port_g_pull_select_pin}};
			port_h_pull_up <= {8{port_h_pull_select_pin}};
			port_h_pull_down <= {8{!port_h_pull_select_pin}};
			wake_request <= next_wake;
			stop_wake <= next_stop_wake;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	// Bus, reset and pin drivers
	a_apb_answer: assert property (
		psel && !penable ##1 psel && penable |=> pready)
		else $error("apb answer late");

	a_dir_write: assert property (
		wr && hit && idx == IDX_H_DIR |=> h_dir == $past(pwdata[7:0]))
		else $error("direction write lost");

	a_reset_inputs: assert property (
		!$past(reset_n) |-> port_g_oe == '0 && port_h_oe == '0)
		else $error("pin driven right after reset");

	// Drivers load from next values, so they match the registers with no lag
	a_oe_direction: assert property (
		!i2c_en |-> port_g_oe == g_dir && port_h_oe == h_dir)
		else $error("output enable differs from direction");

	// Pull outputs register the select pins, one cycle late
	a_pull_select: assert property (
		$past(reset_n) |-> port_g_pull_up == {8{$past(port_g_pull_select_pin)}}
		&& port_h_pull_down == {8{!$past(port_h_pull_select_pin)}})
		else $error("pull direction differs from select pin");

	a_open_drain: assert property (
		i2c_en |-> !port_g_out[BIT_SDA] && !port_g_out[BIT_SCL])
		else $error("open drain pin driven high");

	// Flags in run mode; a set wins over a clear in the same cycle
	a_run_fall_flag: assert property (
		!stop_mode && !i2c_en && fall[0] |=> g_flags[0])
		else $error("run falling edge did not set flag");

	a_output_edge: assert property (
		!stop_mode && fall[9] && h_dir[1] |=> h_flags[1])
		else $error("edge on output pin lost");

	a_flag_seven_zero: assert property (
		!g_flags[7] && !(pready && !pslverr && idx == IDX_G_FLAGS && prdata[7]))
		else $error("port G flag seven not zero");

	a_w1c_clears: assert property (
		wr && hit && idx == IDX_H_FLAGS && pwdata[3] && !set_run[11] && !set_stop[11]
		|=> !h_flags[3])
		else $error("write one did not clear flag");

	a_set_wins: assert property (
		wr && hit && idx == IDX_G_FLAGS && pwdata[2] && set_run[2] |=> g_flags[2])
		else $error("edge lost during clear");

	a_start_detect: assert property (
		!stop_mode && i2c_en && fall[BIT_SDA] && !sync_b[BIT_SCL] && !g_flags[6]
		&& !(wr && idx == IDX_G_ENA) |=> !g_flags[6])
		else $error("start flag set without start");

	a_start_sets: assert property (
		!stop_mode && i2c_en && start_seen |=> g_flags[BIT_SDA])
		else $error("start condition not flagged");

	a_wake_combined: assert property (
		wake_request == |({h_flags, g_flags} & ena16))
		else $error("wake request mismatch");

	// Stop filter and wake path
	a_filter_bypass: assert property (
		!stop_mode |=> fstate == F_IDLE)
		else $error("filter active outside stop");

	// Only the vote may set a flag while stopped
	a_stop_flags_held: assert property (
		stop_mode && fstate != F_THREE && !(wr && hit)
		|=> h_flags == $past(h_flags) && g_flags == $past(g_flags))
		else $error("flag changed in stop without vote");

	a_vote_accept: assert property (
		stop_mode && fstate == F_THREE && tick && lows >= VOTE_MIN
		|=> ({h_flags, g_flags} & $past(filt_pend)) == $past(filt_pend))
		else $error("valid vote did not set flag");

	// A pulse shorter than one tick leaves at most one low sample
	a_vote_reject: assert property (
		stop_mode && fstate == F_THREE && tick && lows == 2'h0 && !(wr && hit)
		|=> (h_flags & ~$past(h_flags)) == '0 && (g_flags & ~$past(g_flags)) == '0)
		else $error("short pulse set a flag");

	a_stop_wake_path: assert property (
		stop_mode && |(~port_h_in & h_ena) |=> stop_wake)
		else $error("enabled low pin did not wake");

	c_run_wake: cover property (!stop_mode && fall[0] ##1 wake_request);
	c_stop_reject: cover property (fstate == F_THREE && tick && set_stop == '0);
	c_stop_vote: cover property (fstate == F_THREE && tick && set_stop != '0);
	c_start_cond: cover property (i2c_en && start_seen);
	c_bad_addr: cover property (pready && pslverr);
endmodule : key_wake_port_pair

// *** verification/key_pads.sv ***
// Model of the keys and pull resistors on one port
`timescale 1ns/1ps
module key_pads (
	// Switches to ground and the port drivers
	input  wire logic [7:0] press,
	input  wire logic [7:0] out,
	input  wire logic [7:0] oe,
	input  wire logic [7:0] pull_up,
	// Resolved pin levels
	output logic      [7:0] pin
);
	// A closed key pulls low even against a driver, as on a shared open-drain line
	assign pin = ~press & ((oe & out) | (~oe & pull_up));
endmodule : key_pads

// *** verification/key_wakeup_port_pair_tb.sv ***
// Self-checking bench for the key wake-up port pair
`timescale 1ns/1ps
module key_wakeup_port_pair_tb;
	import key_wake_pkg::*;
	logic              clk, reset_n, psel, penable, pwrite, sel_g, sel_h, stop_mode;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata;
	logic              pready, pslverr, wake_request, stop_wake;
	logic [7:0]        g_pin, g_out, g_oe, g_up, g_dn, press_g;
	logic [7:0]        h_pin, h_out, h_oe, h_up, h_dn, press_h;
	logic [32:0]       notes[$];
	int                failures = 0;
	int                total_checks = 0;

	key_wake_port_pair #(.FILT_CYCLES(2)) dut (.clk(clk), .reset_n(reset_n), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .port_g_in(g_pin), .port_g_out(g_out),
		.port_g_oe(g_oe), .port_g_pull_up(g_up), .port_g_pull_down(g_dn),
		.port_g_pull_select_pin(sel_g), .port_h_in(h_pin), .port_h_out(h_out),
		.port_h_oe(h_oe), .port_h_pull_up(h_up), .port_h_pull_down(h_dn),
		.port_h_pull_select_pin(sel_h), .stop_mode(stop_mode),
		.wake_request(wake_request), .stop_wake(stop_wake));
	key_pads pads_g (.press(press_g), .out(g_out), .oe(g_oe), .pull_up(g_up), .pin(g_pin));
	key_pads pads_h (.press(press_h), .out(h_out), .oe(h_oe), .pull_up(h_up), .pin(h_pin));

	// ----------------
	// Tasks
	// ----------------
	task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
		total_checks++;
		if (seen !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
		input logic [32:0] exp);
		@(posedge clk);
		psel <= 1'b1;
		paddr <= {2'b00, idx, 2'b00};
		pwrite <= w;
		pwdata <= {24'h0, d};
		notes.push_back(exp);
		@(posedge clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait for the answer
		do @(posedge clk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d, 33'h0);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00, {25'h0, e});
	endtask : rd

	task automatic tap(input logic on_g, input int i);
		if (on_g)
			press_g[i] <= 1'b1;
		else
			press_h[i] <= 1'b1;
		repeat (4) @(posedge clk);
		press_g <= 8'h00;
		press_h <= 8'h00;
		repeat (4) @(posedge clk);
	endtask : tap

	task automatic results();
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : results

	// ----------------
	// Clock, monitor, watchdog
	// ----------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	always @(posedge clk) begin
		if (reset_n && pready === 1'b1)
			check("apb answer", {pslverr, prdata}, notes.pop_front());
	end

	initial begin
		repeat (20000) @(posedge clk);
		failures++;
		results();
	end

	// ----------------
	// Scenarios
	// ----------------
	initial begin
		logic [7:0] d;
		logic [7:0] regs [6];
		regs = '{IDX_G_DIR, IDX_H_DIR, IDX_G_ENA, IDX_H_ENA, IDX_G_FLAGS, IDX_H_FLAGS};
		void'($urandom(53959));
		{reset_n, psel, penable, pwrite, stop_mode} = 5'h0;
		{sel_g, sel_h} = 2'b11;
		{paddr, pwdata, press_g, press_h} = '0;
		repeat (10) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		check("port oe", 33'({g_oe, h_oe}), 33'h0);
		foreach (regs[i]) rd(regs[i], 8'h00);
		apb(1'b0, 8'h30, 8'h00, {1'b1, 32'h0});
		for (int i = 0; i < 8; i++) begin
			tap(1'b1, i);
			tap(1'b0, i);
		end
		rd(IDX_G_FLAGS, 8'h7f);
		rd(IDX_H_FLAGS, 8'hff);
		wr(IDX_G_FLAGS, 8'h05);
		rd(IDX_G_FLAGS, 8'h7a);
		wr(IDX_G_FLAGS, 8'hff);
		wr(IDX_H_FLAGS, 8'hff);
		rd(IDX_H_FLAGS, 8'h00);
		wr(IDX_H_ENA, 8'h10);
		tap(1'b0, 4);
		check("wake request", 33'(wake_request), 33'h1);
		wr(IDX_H_FLAGS, 8'h10);
		repeat (3) @(posedge clk);
		check("wake request", 33'(wake_request), 33'h0);
		stop_mode <= 1'b1;
		press_h[4] <= 1'b1;
		repeat (3) @(posedge clk);
		check("stop wake", 33'(stop_wake), 33'h1);
		repeat (20) @(posedge clk);
		stop_mode <= 1'b0;
		press_h <= 8'h00;
		rd(IDX_H_FLAGS, 8'h10);
		wr(IDX_H_FLAGS, 8'hff);
		stop_mode <= 1'b1;
		press_h[4] <= 1'b1;
		@(posedge clk);
		press_h <= 8'h00;
		repeat (20) @(posedge clk);
		stop_mode <= 1'b0;
		rd(IDX_H_FLAGS, 8'h00);
		d = 8'($urandom());
		wr(IDX_G_DIR, d);
		rd(IDX_G_DIR, d);
		check("g oe", 33'(g_oe), 33'(d));
		wr(IDX_H_DIR, 8'hff);
		rd(IDX_H_FLAGS, 8'hff);
		rd(IDX_G_FLAGS, {1'b0, d[6:0]});
		wr(IDX_H_OUT, 8'h0f);
		rd(IDX_H_PINS, 8'h0f);
		check("h out", 33'(h_out), 33'h0f);
		wr(IDX_G_DIR, 8'h00);
		wr(IDX_G_FLAGS, 8'hff);
		wr(IDX_G_ENA, 8'h80);
		tap(1'b1, 6);
		rd(IDX_G_FLAGS, 8'h40);
		wr(IDX_G_OUT, 8'hff);
		wr(IDX_G_DIR, 8'hff);
		@(posedge clk);
		check("g open drain", 33'({g_out[7:6], g_oe[7:6]}), 33'h0);
		rd(IDX_G_PINS, 8'hff);
		rd(IDX_G_OUT, 8'hff);
		sel_h <= 1'b0;
		repeat (3) @(posedge clk);
		check("h pulls", 33'({h_up, h_dn}), 33'h00ff);
		check("g pulls", 33'({g_up, g_dn}), 33'hff00);
		results();
	end
endmodule : key_wakeup_port_pair_tb
